// [pkg/hbridge_defs.vh]
`ifndef HBRIDGE_DEFS_VH
`define HBRIDGE_DEFS_VH

// Clock rate of aclk in kHz
`define CLK_KHZ 100000
// Internal PWM oscillator rate in kHz, tenths
`define PWM_FREQ_KHZ_X10 445
// System clocks per PWM slot (256 slots per PWM period)
`define PWM_SLOT_DIV ((`CLK_KHZ * 10) / (`PWM_FREQ_KHZ_X10 * 256))
// Current limit qualify time in ns, and cycles
`define ILIM_QUAL_NS 3000
`define ILIM_QUAL_CYC ((`ILIM_QUAL_NS * (`CLK_KHZ / 1000)) / 1000)
// Short-protect deglitch in ns, and cycles
`define SHORT_DEG_NS 2000
`define SHORT_DEG_CYC ((`SHORT_DEG_NS * (`CLK_KHZ / 1000)) / 1000)
// Stall deglitch in ms, counted in PWM periods
`define STALL_MS 275
`define STALL_PERIODS ((`STALL_MS * `PWM_FREQ_KHZ_X10) / 10)
// Start ramp to full duty in ms, counted in PWM periods
`define RAMP_MS 12
`define RAMP_PERIODS ((`RAMP_MS * `PWM_FREQ_KHZ_X10) / 10)
// Full-scale duty
`define DUTY_FULL 8'hff
// AXI register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_DUTY 12'h008
// Status bit positions
`define ST_FAULT 0
`define ST_OVERTEMP 1
`define ST_STALL 2
`define ST_SHORT 3
`define ST_ILIM 4
`define ST_SATURATE 5
`define ST_LOWPWR 6

`endif

// [verilog/hbridge_pwm_fault_control.v]
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`include "hbridge_defs.vh"
`default_nettype none

module hbridge_pwm_fault_control (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Analog comparator results (asynchronous)
    input wire fb_below_set,
    input wire set_above_supply,
    input wire current_sense_node,
    input wire [3:0] short_protect,
    input wire overtemp_flag,
    input wire supply_low_lock,
    // Bridge gate drive: high side and low side per leg
    output reg hs_a,
    output reg ls_a,
    output reg hs_b,
    output reg ls_b,
    // Bridge output enable, low means both legs float
    output reg bridge_out_a,
    output reg bridge_out_b,
    // Low power state and host alert
    output reg sleep_mode,
    output reg alert_line_n
);

    // Synchroniser stages for all asynchronous inputs
    reg [8:0] sy1_r;
    reg [8:0] sy2_r;
    // Software direction control
    reg dir_ctl_a;
    reg dir_ctl_b;
    // Previous direction, to spot drive entry
    reg [1:0] dir_prev_r;
    // PWM slot divider and slot counter
    reg [15:0] div_r;
    reg [7:0] slot_r;
    reg per_tick_r;
    // Regulated duty and ramp ceiling
    reg [7:0] duty_r;
    reg [7:0] ceil_r;
    reg [15:0] ramp_cnt_r;
    // Qualify counters
    reg [15:0] ilim_cnt_r;
    reg [15:0] short_cnt_r;
    reg [15:0] stall_cnt_r;
    // Latched faults
    reg stall_flt_r;
    reg short_flt_r;
    // Bus holding registers
    reg aw_got_r;
    reg w_got_r;
    reg [11:0] awaddr_r;
    reg [31:0] wdata_r;

    // Named views of synchronised inputs
    wire fb_low = sy2_r[0];
    wire sat = sy2_r[1];
    wire ilim_in = sy2_r[2];
    wire short_any = |sy2_r[6:3];
    wire hot = sy2_r[7];
    wire uv = sy2_r[8];
    wire drive = dir_ctl_a ^ dir_ctl_b;
    wire coast = ~dir_ctl_a & ~dir_ctl_b;
    wire ilim_active = ilim_cnt_r >= `ILIM_QUAL_CYC;
    wire run_rst = ~aresetn | uv;
    // Full-width divider constant, cut to the counter width on purpose
    wire [31:0] slot_div_w = `PWM_SLOT_DIV;
    wire [15:0] slot_div = slot_div_w[15:0];

    // Saturating increment used by the ramp, qualify and stall counters
    function [15:0] sat_inc;
        input [15:0] v;
        begin
            sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
        end
    endfunction

    // Two-flop synchroniser; first stage read only by second
    always @(posedge aclk) begin
        if (!aresetn) begin
            sy1_r <= 9'h000;
            sy2_r <= 9'h000;
        end else begin
            sy1_r <= {supply_low_lock, overtemp_flag, short_protect,
                      current_sense_node, set_above_supply, fb_below_set};
            sy2_r <= sy1_r;
        end
    end

    // PWM oscillator: slot enable and period tick
    always @(posedge aclk) begin
        if (run_rst) begin
            div_r <= 16'h0000;
            slot_r <= 8'h00;
            per_tick_r <= 1'b0;
        end else begin
            per_tick_r <= 1'b0;
            if (div_r >= slot_div - 16'h0001) begin
                div_r <= 16'h0000;
                slot_r <= slot_r + 8'h01;
                per_tick_r <= (slot_r == 8'hff);
            end else begin
                div_r <= div_r + 16'h0001;
            end
        end
    end

    // Ramp ceiling, one step per stretch of PWM periods
    always @(posedge aclk) begin
        if (run_rst) begin
            dir_prev_r <= 2'b00;
            ceil_r <= 8'h00;
            ramp_cnt_r <= 16'h0000;
        end else begin
            dir_prev_r <= {dir_ctl_a, dir_ctl_b};
            if (drive && !(dir_prev_r == 2'b01 || dir_prev_r == 2'b10)) begin
                ceil_r <= 8'h00;
                ramp_cnt_r <= 16'h0000;
            end else if (!drive) begin
                ceil_r <= 8'h00;
                ramp_cnt_r <= 16'h0000;
            end else if (per_tick_r && ceil_r != `DUTY_FULL) begin
                // Step so full scale lands inside the ramp time
                if (ramp_cnt_r >= (`RAMP_PERIODS / 256) - 1) begin
                    ramp_cnt_r <= 16'h0000;
                    ceil_r <= ceil_r + 8'h01;
                end else begin
                    ramp_cnt_r <= sat_inc(ramp_cnt_r);
                end
            end
        end
    end

    // Current limit and short deglitch counters
    always @(posedge aclk) begin
        if (run_rst) begin
            ilim_cnt_r <= 16'h0000;
            short_cnt_r <= 16'h0000;
        end else begin
            ilim_cnt_r <= ilim_in ? sat_inc(ilim_cnt_r) : 16'h0000;
            // Independent of the current limit path
            short_cnt_r <= short_any ? sat_inc(short_cnt_r) : 16'h0000;
        end
    end

    // Duty regulator, one step per PWM period
    always @(posedge aclk) begin
        if (run_rst || !drive) begin
            duty_r <= 8'h00;
        end else if (per_tick_r) begin
            if (ilim_active) begin
                // Limit overrides regulation upward
                if (duty_r != 8'h00)
                    duty_r <= duty_r - 8'h01;
            end else if (sat) begin
                duty_r <= ceil_r;
            end else if (fb_low) begin
                if (duty_r < ceil_r)
                    duty_r <= duty_r + 8'h01;
            end else if (duty_r != 8'h00) begin
                duty_r <= duty_r - 8'h01;
            end
            if (duty_r > ceil_r)
                duty_r <= ceil_r;
        end
    end

    // Stall and short fault latches
    always @(posedge aclk) begin
        if (run_rst) begin
            stall_cnt_r <= 16'h0000;
            stall_flt_r <= 1'b0;
            short_flt_r <= 1'b0;
        end else begin
            if (!ilim_active) begin
                stall_cnt_r <= 16'h0000;
            end else if (per_tick_r) begin
                stall_cnt_r <= sat_inc(stall_cnt_r);
            end
            // Set wins over the coast clear
            if (ilim_active && stall_cnt_r >= `STALL_PERIODS)
                stall_flt_r <= 1'b1;
            else if (coast)
                stall_flt_r <= 1'b0;
            // Only reset or supply low releases the short latch
            if (short_cnt_r >= `SHORT_DEG_CYC)
                short_flt_r <= 1'b1;
        end
    end

    // Bridge gate drive and alert, all registered
    always @(posedge aclk) begin
        if (run_rst) begin
            hs_a <= 1'b0;
            ls_a <= 1'b0;
            hs_b <= 1'b0;
            ls_b <= 1'b0;
            bridge_out_a <= 1'b0;
            bridge_out_b <= 1'b0;
            sleep_mode <= 1'b1;
            alert_line_n <= ~uv;
        end else begin
            alert_line_n <= ~(stall_flt_r | short_flt_r | hot);
            sleep_mode <= coast;
            if (short_flt_r || hot || coast) begin
                // All switches off, legs float
                hs_a <= 1'b0;
                ls_a <= 1'b0;
                hs_b <= 1'b0;
                ls_b <= 1'b0;
                bridge_out_a <= 1'b0;
                bridge_out_b <= 1'b0;
            end else if (!drive) begin
                // Brake: both legs low
                hs_a <= 1'b0;
                ls_a <= 1'b1;
                hs_b <= 1'b0;
                ls_b <= 1'b1;
                bridge_out_a <= 1'b1;
                bridge_out_b <= 1'b1;
            end else if (slot_r < duty_r || (sat && duty_r == `DUTY_FULL)) begin
                // On time: drive chosen direction
                hs_a <= dir_ctl_a;
                ls_a <= ~dir_ctl_a;
                hs_b <= dir_ctl_b;
                ls_b <= ~dir_ctl_b;
                bridge_out_a <= 1'b1;
                bridge_out_b <= 1'b1;
            end else begin
                // Off time: recirculate through both high sides
                hs_a <= 1'b1;
                ls_a <= 1'b0;
                hs_b <= 1'b1;
                ls_b <= 1'b0;
                bridge_out_a <= 1'b1;
                bridge_out_b <= 1'b1;
            end
        end
    end

    // AXI write channel: address and data in any order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h00000000;
            dir_ctl_a <= 1'b0;
            dir_ctl_b <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                s_axi_wready <= 1'b0;
                // Byte lane 0 only matters
                if (!s_axi_wstrb[0])
                    wdata_r[1:0] <= {dir_ctl_b, dir_ctl_a};
            end
            if (aw_got_r && w_got_r && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                if (awaddr_r[11:2] == `REG_CTRL >> 2) begin
                    dir_ctl_a <= wdata_r[0];
                    dir_ctl_b <= wdata_r[1];
                    s_axi_bresp <= 2'b00;
                end else begin
                    // Status, duty and unmapped: slave error
                    s_axi_bresp <= 2'b10;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // AXI read channel, one read at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr[11:2])
                `REG_CTRL >> 2: s_axi_rdata <= {30'h0, dir_ctl_b, dir_ctl_a};
                `REG_STATUS >> 2: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rdata[`ST_FAULT] <= ~alert_line_n;
                    s_axi_rdata[`ST_OVERTEMP] <= hot;
                    s_axi_rdata[`ST_STALL] <= stall_flt_r;
                    s_axi_rdata[`ST_SHORT] <= short_flt_r;
                    s_axi_rdata[`ST_ILIM] <= ilim_active;
                    s_axi_rdata[`ST_SATURATE] <= sat;
                    s_axi_rdata[`ST_LOWPWR] <= sleep_mode;
                end
                `REG_DUTY >> 2: s_axi_rdata <= {16'h0, ceil_r, duty_r};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // hbridge_pwm_fault_control

`default_nettype wire

// [tb/hbridge_checker_asserts.sv]
`default_nettype none
module hbridge_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus answers
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Sense pins
    input wire logic current_sense_node,
    input wire logic [3:0] short_protect,
    input wire logic overtemp_flag,
    input wire logic supply_low_lock,
    // Bridge and host pins
    input wire logic hs_a,
    input wire logic ls_a,
    input wire logic hs_b,
    input wire logic ls_b,
    input wire logic bridge_out_a,
    input wire logic bridge_out_b,
    input wire logic sleep_mode,
    input wire logic alert_line_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Short run length and its latch, with margin for syncs
    logic [7:0] sh_cnt;
    logic sh_seen;
    wire logic off = !(hs_a | ls_a | hs_b | ls_b);
    wire logic src = overtemp_flag | supply_low_lock | current_sense_node
        | (|short_protect);
    // Supply low clears the latch like a reset does
    always_ff @(posedge aclk) begin
        if (!aresetn || supply_low_lock) begin
            sh_cnt <= 8'h00;
            sh_seen <= 1'b0;
        end else begin
            sh_cnt <= (|short_protect) ? sh_cnt + {7'h0, sh_cnt != 8'hff}
                : 8'h00;
            sh_seen <= sh_seen | (sh_cnt == 8'hd2);
        end
    end
    a_coast_float: assert property (
        sleep_mode |-> off && !bridge_out_a && !bridge_out_b)
        else $error("coast state drives the bridge");
    a_gate_pattern: assert property (
        bridge_out_a && bridge_out_b |-> {hs_a, ls_a, hs_b, ls_b} inside
        {4'h0, 4'h9, 4'h6, 4'ha, 4'h5})
        else $error("illegal gate pattern");
    a_short_latch: assert property (
        sh_seen |-> off && !alert_line_n)
        else $error("short fault not latched off");
    a_overtemp_off: assert property (
        overtemp_flag [*4] |-> off && !alert_line_n)
        else $error("overtemp left bridge on");
    a_supply_low: assert property (
        supply_low_lock [*4] |-> off && !alert_line_n)
        else $error("supply low left bridge on");
    a_alert_cause: assert property (
        $fell(alert_line_n) |-> $past(src) || $past(src, 2)
        || $past(src, 3))
        else $error("alert without a cause");
    a_write_answer: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_read_answer: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    c_short: cover property (sh_seen);
    c_hot: cover property (overtemp_flag [*4]);
    c_brake: cover property (ls_a && ls_b);
endmodule // hbridge_checker
bind hbridge_pwm_fault_control hbridge_checker hbridge_checker_i (.*);
`default_nettype wire

// [tb/host_model.sv]
`default_nettype none
module host_model (
    // Clock
    input wire logic aclk,
    // Write side
    output logic [11:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // Read side
    output logic [11:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_wstrb, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
    end
    // One write; released lines show inverted data
    task automatic write(input logic [11:0] a, input logic [31:0] d,
            output logic [1:0] r, output logic to);
        logic aw;
        logic w;
        int n;
        {aw, w, n, r, to} = {2'b00, 32'd0, 2'b11, 1'b1};
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        while (to && n < 100) begin
            @(posedge aclk);
            n++;
            if (!aw && s_axi_awready) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (!w && s_axi_wready) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
            if (s_axi_bvalid) begin
                {r, to} = {s_axi_bresp, 1'b0};
                s_axi_bready <= 1'b0;
            end
        end
    endtask
    // One read, waits for the answer under a bound
    task automatic read(input logic [11:0] a, output logic [31:0] d,
            output logic [1:0] r, output logic to);
        int n;
        {n, d, r, to} = {32'd0, 32'h0, 2'b11, 1'b1};
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        while (to && n < 100) begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
            if (s_axi_rvalid) begin
                {d, r, to} = {s_axi_rdata, s_axi_rresp, 1'b0};
                s_axi_rready <= 1'b0;
            end
        end
    endtask
    // Direction set once per move, coast also clears a stall
    task automatic set_dir(input logic [1:0] d, output logic [1:0] r,
            output logic to);
        write(12'h000, {30'h0, d}, r, to);
    endtask
endmodule // host_model
`default_nettype wire

// [tb/tb.sv]
`include "hbridge_defs.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Clock, reset and comparator stand-ins
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic fb_below_set = 1'b0;
    logic set_above_supply = 1'b0;
    logic current_sense_node = 1'b0;
    logic [3:0] short_protect = 4'h0;
    logic overtemp_flag = 1'b0;
    logic supply_low_lock = 1'b0;
    // Bus and pin nets
    wire logic [11:0] s_axi_awaddr, s_axi_araddr;
    wire logic [31:0] s_axi_wdata, s_axi_rdata;
    wire logic [3:0] s_axi_wstrb;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    wire logic s_axi_rvalid, s_axi_rready, sleep_mode, alert_line_n;
    wire logic hs_a, ls_a, hs_b, ls_b, bridge_out_a, bridge_out_b;
    int miscompares = 0;
    int check_count = 0;
    logic [31:0] rv;
    logic [1:0] rr;
    logic to;
    always #5 aclk = ~aclk;
    hbridge_pwm_fault_control hbridge_pwm_fault_control_i (.*);
    host_model host_model_i (.*);
    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic test_done();
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // A bus wait that ran out ends the run
    task automatic hung(input logic [1:0] e);
        if (to) begin
            miscompares++;
            test_done();
        end else begin
            chk("resp", 32'(rr), 32'(e));
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [1:0] e);
        host_model_i.read(a, rv, rr, to);
        hung(e);
    endtask
    task automatic dir(input logic [1:0] d);
        host_model_i.set_dir(d, rr, to);
        hung(2'b00);
    endtask
    task automatic pins(input logic [3:0] g, input logic al);
        chk("gates", 32'({hs_a, ls_a, hs_b, ls_b}), 32'(g));
        chk("alert", 32'(alert_line_n), 32'(al));
    endtask
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    // Reset state, refused and unmapped accesses
    task automatic t_regs();
        pins(4'h0, 1'b1);
        rd(`REG_STATUS, 2'b00);
        chk("status", rv, 32'h1 << `ST_LOWPWR);
        rd(12'h00c, 2'b10);
        chk("unmapped", rv, 32'h0);
        host_model_i.write(`REG_STATUS, 32'h3, rr, to);
        hung(2'b10);
        rd(`REG_CTRL, 2'b00);
        chk("ctrl", rv, 32'h0);
    endtask
    // Every direction code, then a setpoint above supply
    task automatic t_decode();
        logic [15:0] gt = 16'h05aa;
        for (int i = 0; i < 4; i++) begin
            dir(2'(i + 1));
            repeat (5) @(posedge aclk);
            pins(gt[i*4 +: 4], 1'b1);
            chk("legs", 32'({bridge_out_a, bridge_out_b}),
                32'({2{i != 3}}));
            chk("sleep", 32'(sleep_mode), 32'(i == 3));
        end
        dir(2'b01);
        set_above_supply <= 1'b1;
        repeat (2100) @(posedge aclk);
        rd(`REG_STATUS, 2'b00);
        chk("saturate", 32'(rv[`ST_SATURATE]), 32'h1);
        set_above_supply <= 1'b0;
    endtask
    // Duty rises below setpoint, falls above, restarts at zero
    task automatic t_reg();
        logic [7:0] up;
        dir(2'b11);
        dir(2'b01);
        rd(`REG_DUTY, 2'b00);
        chk("duty start", rv, 32'h0);
        fb_below_set <= 1'b1;
        repeat (24576) @(posedge aclk);
        rd(`REG_DUTY, 2'b00);
        up = rv[7:0];
        chk("duty up", 32'(up != 8'h00), 32'h1);
        fb_below_set <= 1'b0;
        repeat (4096) @(posedge aclk);
        rd(`REG_DUTY, 2'b00);
        chk("duty down", 32'(rv[7:0] < up), 32'h1);
        dir(2'b11);
        dir(2'b01);
        rd(`REG_DUTY, 2'b00);
        chk("duty again", 32'(rv[7:0]), 32'h0);
        current_sense_node <= 1'b1;
        repeat (400) @(posedge aclk);
        rd(`REG_STATUS, 2'b00);
        chk("ilim", 32'(rv[`ST_ILIM]), 32'h1);
        chk("no stall", 32'(alert_line_n), 32'h1);
        current_sense_node <= 1'b0;
    endtask
    // Per-switch short: glitch ignored, long one latched
    task automatic t_short();
        for (int k = 0; k < 4; k++) begin
            dir(2'b01);
            short_protect[k] <= 1'b1;
            repeat (120) @(posedge aclk);
            short_protect[k] <= 1'b0;
            repeat (5) @(posedge aclk);
            pins(4'ha, 1'b1);
            short_protect[k] <= 1'b1;
            repeat (250) @(posedge aclk);
            short_protect[k] <= 1'b0;
            dir(2'b00);
            dir(2'b01);
            repeat (5) @(posedge aclk);
            pins(4'h0, 1'b0);
            rd(`REG_STATUS, 2'b00);
            chk("short", 32'(rv[`ST_SHORT]), 32'h1);
            do_reset();
        end
    endtask
    // Overtemp recovers by itself; supply low resets
    task automatic t_temp_uv();
        dir(2'b01);
        overtemp_flag <= 1'b1;
        repeat (5) @(posedge aclk);
        pins(4'h0, 1'b0);
        rd(`REG_STATUS, 2'b00);
        chk("hot", 32'(rv[1:0]), 32'h3);
        overtemp_flag <= 1'b0;
        repeat (5) @(posedge aclk);
        pins(4'ha, 1'b1);
        supply_low_lock <= 1'b1;
        repeat (5) @(posedge aclk);
        pins(4'h0, 1'b0);
        supply_low_lock <= 1'b0;
        repeat (5) @(posedge aclk);
        chk("alert", 32'(alert_line_n), 32'h1);
    endtask
    initial begin
        do_reset();
        t_regs();
        t_decode();
        t_reg();
        t_short();
        t_temp_uv();
        test_done();
    end
endmodule // tb
`default_nettype wire
